// ===== src/qd_ctrl.v
// quadrature decoder control: registers, tasks, events, links and pin ownership
`timescale 1ns/1ps
`include "qd_defines.vh"

module qd_ctrl #(
  parameter [23:0] SAMPLE_BASE_CYCLES = `QD_SAMPLE_BASE_CYC,
  parameter [7:0]  LAMP_US_CYCLES     = `QD_LAMP_US_CYC
) (
  // clock and reset
  input  wire        clk,
  input  wire        resetn,
  // register port
  input  wire [11:0] addr,
  input  wire [31:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [31:0] rdata,
  // pads and gpio block
  input  wire [31:0] pin_in,
  input  wire [31:0] gpio_out,
  input  wire [31:0] gpio_oe,
  output reg  [31:0] pad_out,
  output reg  [31:0] pad_oe,
  // interrupt
  output reg         irq
);

  // software-visible state
  reg        decoder_enable;
  reg        lamp_polarity;
  reg [3:0]  step_interval_select;
  reg [7:0]  report_interval;
  reg [31:0] lamp_pin_select;
  reg [31:0] phase_first_pin_select;
  reg [31:0] phase_second_pin_select;
  reg        debounce_enable;
  reg [8:0]  lamp_lead_time;
  reg [6:0]  event_task_links;
  reg [4:0]  irq_enable;
  reg [4:0]  event_flags;
  reg [1:0]  motion_step_value;
  reg [10:0] motion_total;
  reg [10:0] motion_total_snapshot;
  reg [3:0]  double_error_count;
  reg [3:0]  double_error_snapshot;
  // internal state
  reg        running;
  reg        prime;
  reg [23:0] interval_timer;
  reg [7:0]  report_count;
  reg        link_both;
  reg        link_total;
  reg        link_double;
  reg        link_stop;

  // register write decode, shared by the task triggers and the event flag writes
  function wr_hit;
    input        strobe;
    input [11:0] a;
    input [11:0] off;
    begin
      wr_hit = strobe & (a == off);
    end
  endfunction

  // pin select helpers
  function sel_connected;
    input [31:0] sel;
    begin
      sel_connected = ~sel[`QD_PSEL_CONNECT] & ~sel[`QD_PSEL_PORT];
    end
  endfunction

  // triggers fire only on a written 1
  wire sw_start  = wr_hit(wr, addr, `QD_OFF_START) & wdata[0];
  wire sw_stop   = wr_hit(wr, addr, `QD_OFF_STOP) & wdata[0];
  wire sw_both   = wr_hit(wr, addr, `QD_OFF_SNAP_BOTH) & wdata[0];
  wire sw_total  = wr_hit(wr, addr, `QD_OFF_SNAP_TOTAL) & wdata[0];
  wire sw_double = wr_hit(wr, addr, `QD_OFF_SNAP_DOUBLE) & wdata[0];
  // software tasks and linked tasks merge here
  wire task_stop   = sw_stop | link_stop;
  wire task_start  = sw_start & decoder_enable & ~task_stop;
  wire snap_total  = sw_both | sw_total | link_both | link_total;
  wire snap_double = sw_both | sw_double | link_both | link_double;

  // sample interval: base period doubled per select step
  wire [3:0]  sel_clamped = (step_interval_select > `QD_SEL_MAX) ?
                            `QD_SEL_MAX : step_interval_select;
  wire [23:0] period_cycles = SAMPLE_BASE_CYCLES << sel_clamped;
  wire        tick = running & (interval_timer == 24'h00_0000);

  // phase levels from the selected pads, only while enabled
  wire        first_on  = decoder_enable & sel_connected(phase_first_pin_select);
  wire        second_on = decoder_enable & sel_connected(phase_second_pin_select);
  wire        lamp_on   = decoder_enable & sel_connected(lamp_pin_select);
  wire [4:0]  first_idx  = phase_first_pin_select[`QD_PSEL_PIN_HI:0];
  wire [4:0]  second_idx = phase_second_pin_select[`QD_PSEL_PIN_HI:0];
  wire [4:0]  lamp_idx   = lamp_pin_select[`QD_PSEL_PIN_HI:0];
  wire        phase_first  = first_on & pin_in[first_idx];
  wire        phase_second = second_on & pin_in[second_idx];
  wire       step_valid;
  wire [1:0] step_code;
  qd_sampler u_sampler (
    .clk          (clk),
    .resetn       (resetn),
    .prime        (prime),
    .tick         (tick),
    .phase_first  (phase_first),
    .phase_second (phase_second),
    .step_valid   (step_valid),
    .step_code    (step_code)
  );

  // accumulate one step; values that would leave the range are dropped
  reg [10:0] next_total;
  reg [3:0]  next_double;
  reg        overflow;
  always @* begin
    next_total  = motion_total;
    next_double = double_error_count;
    overflow    = 1'b0;
    if (step_valid) begin
      case (step_code)
        `QD_STEP_FWD: begin
          if (motion_total == `QD_TOTAL_MAX) overflow = 1'b1;
          else next_total = motion_total + 11'h001;
        end
        `QD_STEP_BACK: begin
          if (motion_total == `QD_TOTAL_MIN) overflow = 1'b1;
          else next_total = motion_total - 11'h001;
        end
        `QD_STEP_DOUBLE: begin
          if (double_error_count == `QD_DOUBLE_MAX) overflow = 1'b1;
          else next_double = double_error_count + 4'h1;
        end
        default: next_total = motion_total;
      endcase
    end
  end

  // report window closes after the configured number of samples
  wire [7:0] report_target = (report_interval == 8'h00) ? 8'h01 : report_interval;
  wire       report_due    = step_valid & (report_count == report_target - 8'h01);

  // events of this cycle
  wire ev_step     = step_valid;
  wire ev_report   = report_due & (next_total != 11'h000);
  wire ev_double   = report_due & (next_double != 4'h0);
  wire ev_overflow = overflow;
  wire ev_halted   = task_stop;                                    // even when idle
  wire [4:0] ev_vec = {ev_halted, ev_double, ev_overflow, ev_report, ev_step};

  // run control, interval timer and report counter
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      running        <= 1'b0;
      prime          <= 1'b0;
      interval_timer <= 24'h00_0000;
      report_count   <= 8'h00;
    end else begin
      prime <= task_start;
      if (task_stop || !decoder_enable) begin
        running <= 1'b0;
      end else if (task_start) begin
        running        <= 1'b1;
        interval_timer <= period_cycles - 24'h00_0001;
        report_count   <= 8'h00;
      end else if (running) begin
        if (tick) interval_timer <= period_cycles - 24'h00_0001;
        else interval_timer <= interval_timer - 24'h00_0001;
        if (report_due) report_count <= 8'h00;
        else if (step_valid) report_count <= report_count + 8'h01;
      end
    end
  end

  // accumulators, snapshots and the latest step value
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      motion_step_value     <= `QD_STEP_NONE;
      motion_total          <= 11'h000;
      motion_total_snapshot <= 11'h000;
      double_error_count    <= 4'h0;
      double_error_snapshot <= 4'h0;
    end else begin
      if (step_valid) motion_step_value <= step_code;
      // snapshot takes this cycle's step too, so nothing slips between copy and clear
      if (snap_total) begin
        motion_total_snapshot <= next_total;
        motion_total          <= 11'h000;
      end else begin
        motion_total <= next_total;
      end
      if (snap_double) begin
        double_error_snapshot <= next_double;
        double_error_count    <= 4'h0;
      end else begin
        double_error_count <= next_double;
      end
    end
  end

  // linked tasks run one cycle after their event
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      link_both   <= 1'b0;
      link_total  <= 1'b0;
      link_double <= 1'b0;
      link_stop   <= 1'b0;
    end else begin
      link_both   <= (ev_report & event_task_links[`QD_LK_REPORT_BOTH]) |
                     (ev_step & event_task_links[`QD_LK_STEP_BOTH]);
      link_total  <= ev_report & event_task_links[`QD_LK_REPORT_TOTAL];
      link_double <= ev_double & event_task_links[`QD_LK_DOUBLE_DOUBLE];
      link_stop   <= (ev_step & event_task_links[`QD_LK_STEP_STOP]) |
                     (ev_report & event_task_links[`QD_LK_REPORT_STOP]) |
                     (ev_double & event_task_links[`QD_LK_DOUBLE_STOP]);
    end
  end

  // event flags: hardware set wins over a software clear in the same cycle
  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : g_flag
      localparam integer FLAG_STEP = 4 * g;
      wire flag_wr = wr_hit(wr, addr, `QD_OFF_EV_STEP + FLAG_STEP[11:0]);
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          event_flags[g] <= 1'b0;
        end else if (ev_vec[g]) begin
          event_flags[g] <= 1'b1;
        end else if (flag_wr) begin
          event_flags[g] <= wdata[0];
        end
      end
    end
  endgenerate

  // configuration registers
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      decoder_enable          <= 1'b0;
      lamp_polarity           <= 1'b0;
      step_interval_select    <= 4'h0;
      report_interval         <= `QD_RST_REPORT;
      lamp_pin_select         <= `QD_RST_PSEL;
      phase_first_pin_select  <= `QD_RST_PSEL;
      phase_second_pin_select <= `QD_RST_PSEL;
      debounce_enable         <= 1'b0;
      lamp_lead_time          <= `QD_RST_LEAD;
      event_task_links        <= 7'h00;
      irq_enable              <= 5'h00;
    end else if (wr) begin
      case (addr)
        `QD_OFF_ENABLE:      decoder_enable          <= wdata[0];
        `QD_OFF_LAMP_POL:    lamp_polarity           <= wdata[0];
        `QD_OFF_STEP_SEL:    step_interval_select    <= wdata[3:0];
        `QD_OFF_REPORT:      report_interval         <= wdata[7:0];
        `QD_OFF_PSEL_LAMP:   lamp_pin_select         <= wdata;
        `QD_OFF_PSEL_FIRST:  phase_first_pin_select  <= wdata;
        `QD_OFF_PSEL_SECOND: phase_second_pin_select <= wdata;
        `QD_OFF_DEBOUNCE:    debounce_enable         <= wdata[0];
        `QD_OFF_LAMP_LEAD:   lamp_lead_time          <= wdata[8:0];
        `QD_OFF_LINKS:       event_task_links        <= wdata[6:0];
        `QD_OFF_IRQ_SET:     irq_enable <= irq_enable | wdata[4:0];
        `QD_OFF_IRQ_CLR:     irq_enable <= irq_enable & ~wdata[4:0];
        default:             irq_enable <= irq_enable;
      endcase
    end
  end

  // read mux; unmapped and write-only offsets read as zero
  reg [31:0] next_rdata;
  always @* begin
    case (addr)
      `QD_OFF_EV_STEP:     next_rdata = {31'h0, event_flags[`QD_EV_STEP]};
      `QD_OFF_EV_REPORT:   next_rdata = {31'h0, event_flags[`QD_EV_REPORT]};
      `QD_OFF_EV_OVERFLOW: next_rdata = {31'h0, event_flags[`QD_EV_OVERFLOW]};
      `QD_OFF_EV_DOUBLE:   next_rdata = {31'h0, event_flags[`QD_EV_DOUBLE]};
      `QD_OFF_EV_HALTED:   next_rdata = {31'h0, event_flags[`QD_EV_HALTED]};
      `QD_OFF_LINKS:       next_rdata = {25'h0, event_task_links};
      `QD_OFF_IRQ_SET:     next_rdata = {27'h0, irq_enable};
      `QD_OFF_IRQ_CLR:     next_rdata = {27'h0, irq_enable};
      `QD_OFF_ENABLE:      next_rdata = {31'h0, decoder_enable};
      `QD_OFF_LAMP_POL:    next_rdata = {31'h0, lamp_polarity};
      `QD_OFF_STEP_SEL:    next_rdata = {28'h0, step_interval_select};
      `QD_OFF_STEP_VALUE:  next_rdata = {{30{&motion_step_value}}, motion_step_value};
      `QD_OFF_REPORT:      next_rdata = {24'h0, report_interval};
      `QD_OFF_TOTAL:       next_rdata = {{21{motion_total[10]}}, motion_total};
      `QD_OFF_TOTAL_SNAP:  next_rdata = {{21{motion_total_snapshot[10]}}, motion_total_snapshot};
      `QD_OFF_PSEL_LAMP:   next_rdata = lamp_pin_select;
      `QD_OFF_PSEL_FIRST:  next_rdata = phase_first_pin_select;
      `QD_OFF_PSEL_SECOND: next_rdata = phase_second_pin_select;
      `QD_OFF_DEBOUNCE:    next_rdata = {31'h0, debounce_enable};
      `QD_OFF_LAMP_LEAD:   next_rdata = {23'h0, lamp_lead_time};
      `QD_OFF_DOUBLE:      next_rdata = {28'h0, double_error_count};
      `QD_OFF_DOUBLE_SNAP: next_rdata = {28'h0, double_error_snapshot};
      default:             next_rdata = `QD_RST_ZERO;
    endcase
  end

  // lamp lights a lead time before each sample, steady while debouncing
  wire [23:0] lead_cycles = {15'h0000, lamp_lead_time} * {16'h0000, LAMP_US_CYCLES};
  wire        lamp_lit    = running & (debounce_enable | (interval_timer <= lead_cycles));
  wire        lamp_level  = lamp_polarity ? lamp_lit : ~lamp_lit;

  // pad ownership per pin; the lamp claim is checked first, since software
  // keeps every pin to one driver and an overlap is undefined anyway
  wire [31:0] next_pad_out;
  wire [31:0] next_pad_oe;
  generate
    for (g = 0; g < 32; g = g + 1) begin : g_pad
      localparam integer PIN_NUM = g;
      wire lamp_here  = lamp_on & (lamp_idx == PIN_NUM[4:0]);
      wire phase_here = (first_on & (first_idx == PIN_NUM[4:0])) |
                        (second_on & (second_idx == PIN_NUM[4:0]));
      // phase pins stay undriven: cpu writes have no effect, pad still readable
      assign next_pad_out[g] = lamp_here ? lamp_level :
                               phase_here ? 1'b0 : gpio_out[g];
      assign next_pad_oe[g]  = lamp_here ? 1'b1 :
                               phase_here ? 1'b0 : gpio_oe[g];
    end
  endgenerate

  // registered outputs; read data stands only in the cycle after the strobe
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata   <= `QD_RST_ZERO;
      pad_out <= `QD_RST_ZERO;
      pad_oe  <= `QD_RST_ZERO;
      irq     <= 1'b0;
    end else begin
      rdata   <= rd ? next_rdata : `QD_RST_ZERO;
      pad_out <= next_pad_out;
      pad_oe  <= next_pad_oe;
      irq     <= |(event_flags & irq_enable);
    end
  end

endmodule // qd_ctrl

// ===== src/qd_defines.vh
// register offsets, field positions, reset values and timing for the quadrature decoder
`ifndef QD_DEFINES_VH
`define QD_DEFINES_VH

// register offsets (byte addresses)
`define QD_OFF_START        12'h000
`define QD_OFF_STOP         12'h004
`define QD_OFF_SNAP_BOTH    12'h008
`define QD_OFF_SNAP_TOTAL   12'h00C
`define QD_OFF_SNAP_DOUBLE  12'h010
`define QD_OFF_EV_STEP      12'h100
`define QD_OFF_EV_REPORT    12'h104
`define QD_OFF_EV_OVERFLOW  12'h108
`define QD_OFF_EV_DOUBLE    12'h10C
`define QD_OFF_EV_HALTED    12'h110
`define QD_OFF_LINKS        12'h200
`define QD_OFF_IRQ_SET      12'h304
`define QD_OFF_IRQ_CLR      12'h308
`define QD_OFF_ENABLE       12'h500
`define QD_OFF_LAMP_POL     12'h504
`define QD_OFF_STEP_SEL     12'h508
`define QD_OFF_STEP_VALUE   12'h50C
`define QD_OFF_REPORT       12'h510
`define QD_OFF_TOTAL        12'h514
`define QD_OFF_TOTAL_SNAP   12'h518
`define QD_OFF_PSEL_LAMP    12'h51C
`define QD_OFF_PSEL_FIRST   12'h520
`define QD_OFF_PSEL_SECOND  12'h524
`define QD_OFF_DEBOUNCE     12'h528
`define QD_OFF_LAMP_LEAD    12'h540
`define QD_OFF_DOUBLE       12'h544
`define QD_OFF_DOUBLE_SNAP  12'h548

// event bit positions, shared by flags and interrupt enables
`define QD_EV_STEP      0
`define QD_EV_REPORT    1
`define QD_EV_OVERFLOW  2
`define QD_EV_DOUBLE    3
`define QD_EV_HALTED    4

// event-to-task link bit positions
`define QD_LK_REPORT_BOTH    0
`define QD_LK_STEP_STOP      1
`define QD_LK_REPORT_TOTAL   2
`define QD_LK_REPORT_STOP    3
`define QD_LK_DOUBLE_DOUBLE  4
`define QD_LK_DOUBLE_STOP    5
`define QD_LK_STEP_BOTH      6

// pin select fields
`define QD_PSEL_CONNECT  31
`define QD_PSEL_PORT     5
`define QD_PSEL_PIN_HI   4

// reset values
`define QD_RST_ZERO     32'h0000_0000
`define QD_RST_PSEL     32'hFFFF_FFFF
`define QD_RST_REPORT   8'h0A
`define QD_RST_LEAD     9'h010

// step codes, two's complement with 2'b10 meaning double transition
`define QD_STEP_NONE    2'b00
`define QD_STEP_FWD     2'b01
`define QD_STEP_DOUBLE  2'b10
`define QD_STEP_BACK    2'b11

// accumulator limits and the largest step interval select
`define QD_TOTAL_MAX    11'h3FF
`define QD_TOTAL_MIN    11'h400
`define QD_DOUBLE_MAX   4'hF
`define QD_SEL_MAX      4'hA

// timing: clock rate and shortest sample period
`define QD_CLK_MHZ          20
`define QD_SAMPLE_BASE_US   128
`define QD_SAMPLE_BASE_CYC  24'h00_0A00  // 128 us at 20 MHz, sized for its parameter
`define QD_LAMP_US_CYC      8'h14        // one microsecond at 20 MHz

`endif

// ===== src/qd_sampler.v
// phase pair sampler and transition decoder
`timescale 1ns/1ps
`include "qd_defines.vh"

module qd_sampler (
  // clock and reset
  input  wire       clk,
  input  wire       resetn,
  // control
  input  wire       prime,
  input  wire       tick,
  // phase levels
  input  wire       phase_first,
  input  wire       phase_second,
  // decoded step
  output reg        step_valid,
  output reg  [1:0] step_code
);

  reg  [1:0] prev_pair;
  wire [1:0] cur_pair = {phase_first, phase_second};

  // position of a pair on the quadrature cycle 00-01-11-10
  function [1:0] cycle_pos;
    input [1:0] pair;
    begin
      case (pair)
        2'b00:   cycle_pos = 2'd0;
        2'b01:   cycle_pos = 2'd1;
        2'b11:   cycle_pos = 2'd2;
        default: cycle_pos = 2'd3;
      endcase
    end
  endfunction

  // difference of positions mod 4 is the step code directly:
  // 1 forward, 3 backward, 2 both phases moved, 0 idle
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prev_pair  <= 2'b00;
      step_valid <= 1'b0;
      step_code  <= `QD_STEP_NONE;
    end else if (prime) begin
      prev_pair  <= cur_pair;          // first sample after start has a clean reference
      step_valid <= 1'b0;
    end else if (tick) begin
      prev_pair  <= cur_pair;
      step_valid <= 1'b1;
      step_code  <= cycle_pos(cur_pair) - cycle_pos(prev_pair);
    end else begin
      step_valid <= 1'b0;
    end
  end

endmodule // qd_sampler

// ===== sim/qd_encoder_model.sv
// encoder stand-in: two phase levels stepped on command
`timescale 1ns/1ps
module qd_encoder_model (
  // clock and step command: 0 hold, 1 fwd, 2 back, 3 skip
  input  wire       clk,
  input  wire [1:0] cmd,
  // phase levels
  output wire       ph_a,
  output wire       ph_b
);
  reg [1:0] pos = 2'h0;
  // skip jumps two states, which the decoder must see as a double
  always @(posedge clk) begin
    pos <= pos + ((cmd == 2'h2) ? 2'h3 : ((cmd == 2'h3) ? 2'h2 : {1'b0, cmd[0]}));
  end
  // gray order 00,01,11,10 on (a,b)
  assign ph_a = pos[1];
  assign ph_b = pos[1] ^ pos[0];
endmodule // qd_encoder_model

// ===== sim/qd_ctrl_props.sv
// port assertions for the decoder control block
`timescale 1ns/1ps
module qd_ctrl_props (
  // clock, reset and register port
  input wire        clk,
  input wire        resetn,
  input wire [11:0] addr,
  input wire [31:0] wdata,
  input wire        wr,
  input wire        rd,
  input wire [31:0] rdata,
  // pads and interrupt
  input wire [31:0] gpio_out,
  input wire [31:0] gpio_oe,
  input wire [31:0] pad_out,
  input wire [31:0] pad_oe,
  input wire        irq
);
  reg        en_sh;
  reg [6:0]  lk_sh;
  reg [4:0]  ien_sh;
  reg [31:0] lp_sh;
  // shadows followed from bus writes; the checker cannot see inside
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      en_sh <= 1'b0;
      lk_sh <= 7'h00;
      ien_sh <= 5'h00;
      lp_sh <= 32'hffff_ffff;
    end else if (wr) begin
      if (addr == 12'h500) en_sh <= wdata[0];
      if (addr == 12'h200) lk_sh <= wdata[6:0];
      if (addr == 12'h51c) lp_sh <= wdata;
      if (addr == 12'h304) ien_sh <= ien_sh | wdata[4:0];
      if (addr == 12'h308) ien_sh <= ien_sh & ~wdata[4:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  gpio_follow_a: assert property ($past(resetn) && !$past(en_sh) |->
    pad_out == $past(gpio_out) && pad_oe == $past(gpio_oe)) else $error("pads not gpio");
  irq_en_rb_a: assert property (rd && (addr == 12'h304 || addr == 12'h308) |=>
    rdata == {27'h0, ien_sh}) else $error("irq enable readback");
  links_rb_a: assert property (rd && addr == 12'h200 |=> rdata == {25'h0, lk_sh})
    else $error("links readback");
  halt_flag_a: assert property (wr && addr == 12'h004 && wdata[0] ##1 !wr [*2]
    ##1 rd && addr == 12'h110 |=> rdata[0]) else $error("no halted flag");
  irq_on_a: assert property (ien_sh[0] && wr && addr == 12'h100 && wdata[0] ##1 !wr
    |=> irq) else $error("irq missing");
  irq_off_a: assert property (wr && addr == 12'h308 && wdata[4:0] == 5'h1f
    ##1 !(wr && addr == 12'h304) |=> !irq) else $error("irq stuck");
  lamp_own_a: assert property ($past(en_sh) && $past(lp_sh) == 32'h0000_0002
    |-> pad_oe[2]) else $error("lamp pin not owned");
  lamp_off_a: assert property ($past(en_sh && lp_sh[31] && !gpio_oe[2]) |-> !pad_oe[2])
    else $error("disconnected lamp driven");
  irq_c: cover property ($rose(irq));
  lamp_c: cover property (en_sh && pad_oe[2]);
  halt_c: cover property (rd && addr == 12'h110);
endmodule // qd_ctrl_props

bind qd_ctrl qd_ctrl_props i_qd_ctrl_props (.clk(clk), .resetn(resetn), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .gpio_out(gpio_out),
  .gpio_oe(gpio_oe), .pad_out(pad_out), .pad_oe(pad_oe), .irq(irq));

// ===== sim/qd_ctrl_tb_top.sv
// self-checking bench for the decoder control block
`timescale 1ns/1ps
module qd_ctrl_tb_top;
  reg         clk = 1'b0;
  reg         resetn = 1'b0;
  reg  [11:0] addr = 12'h000;
  reg  [31:0] wdata = 32'h0000_0000;
  reg         wr = 1'b0;
  reg         rd = 1'b0;
  reg  [31:0] gpio_out = 32'h0000_0000;
  reg  [31:0] gpio_oe = 32'h0000_0000;
  reg  [31:0] pin_rnd = 32'h0000_0000;
  reg  [1:0]  cmd = 2'h0;
  reg         en_tb = 1'b0;
  wire [31:0] rdata, pad_out, pad_oe, pin_in;
  wire        irq, ph_a, ph_b;
  integer     seed = 35;
  integer     failures = 0;
  integer     samples_checked = 0;
  integer     nf, nb, nd;
  initial begin
    forever #25 clk = ~clk;
  end
  assign pin_in = {pin_rnd[31:2], ph_b, ph_a};
  // short base period keeps each sample interval at 8 cycles
  qd_ctrl #(.SAMPLE_BASE_CYCLES(24'd8), .LAMP_US_CYCLES(8'd1)) i_qd_ctrl (.clk(clk),
    .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .pin_in(pin_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .pad_out(pad_out),
    .pad_oe(pad_oe), .irq(irq));
  qd_encoder_model i_qd_encoder_model (.clk(clk), .cmd(cmd), .ph_a(ph_a), .ph_b(ph_b));
  // gpio noise; decoder pins stay gpio inputs while enabled
  always @(posedge clk) begin
    gpio_out <= $random(seed);
    gpio_oe <= $random(seed) & (en_tb ? 32'hffff_fff8 : 32'hffff_ffff);
    pin_rnd <= $random(seed);
  end
  task automatic chk(input [31:0] got, input [31:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input [11:0] a, input [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input [11:0] a, input [31:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, exp);
  endtask
  // moves spaced wider than a sample interval, so each is seen once
  task automatic mv(input [1:0] c, input integer n);
    repeat (n) begin
      @(posedge clk);
      cmd <= c;
      @(posedge clk);
      cmd <= 2'h0;
      repeat (22) @(posedge clk);
    end
  endtask
  function automatic [31:0] net(input integer f, input integer b);
    net = f - b;
  endfunction
  task automatic final_report;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // the sequence needs at most about 660 cycles
  initial begin
    repeat (20000) @(posedge clk);
    failures = failures + 1;
    final_report;
  end
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    rd_chk(12'h200, 32'h0000_0000);
    rd_chk(12'h51c, 32'hffff_ffff);
    rd_chk(12'h600, 32'h0000_0000);
    wr_reg(12'h200, $random(seed));
    rd_chk(12'h200, {25'h0, wdata[6:0]});
    wr_reg(12'h200, 32'h0000_0000);
    wr_reg(12'h304, 32'h0000_001f);
    wr_reg(12'h304, 32'h0000_0000);
    rd_chk(12'h308, 32'h0000_001f);
    wr_reg(12'h100, 32'h0000_0001);
    repeat (2) @(posedge clk);
    @(negedge clk) chk({31'h0, irq}, 32'h0000_0001);
    wr_reg(12'h308, 32'h0000_001f);
    wr_reg(12'h100, 32'h0000_0000);
    $display("registers and irq done");
    en_tb <= 1'b1;
    wr_reg(12'h51c, 32'h0000_0002);
    wr_reg(12'h520, 32'h0000_0000);
    wr_reg(12'h524, 32'h0000_0001);
    wr_reg(12'h510, 32'h0000_0001);
    wr_reg(12'h500, 32'h0000_0001);
    wr_reg(12'h000, 32'h0000_0001);
    repeat (24) @(posedge clk);
    @(negedge clk) chk({29'h0, pad_oe[2:0]}, 32'h0000_0004);
    nf = 1 + ($random(seed) & 7);
    nb = $random(seed) & 3;
    nd = 1 + ($random(seed) & 3);
    mv(2'h1, nf);
    mv(2'h2, nb);
    mv(2'h3, nd);
    rd_chk(12'h514, net(nf, nb));
    rd_chk(12'h544, nd);
    rd_chk(12'h100, 32'h0000_0001);
    wr_reg(12'h00c, 32'h0000_0001);
    rd_chk(12'h518, net(nf, nb));
    rd_chk(12'h514, 32'h0000_0000);
    rd_chk(12'h544, nd);
    wr_reg(12'h104, 32'h0000_0000);
    repeat (24) @(posedge clk);
    rd_chk(12'h104, 32'h0000_0000);
    mv(2'h1, 1);
    rd_chk(12'h104, 32'h0000_0001);
    wr_reg(12'h008, 32'h0000_0001);
    rd_chk(12'h518, 32'h0000_0001);
    rd_chk(12'h548, nd);
    rd_chk(12'h544, 32'h0000_0000);
    wr_reg(12'h10c, 32'h0000_0000);
    mv(2'h3, 1);
    rd_chk(12'h10c, 32'h0000_0001);
    wr_reg(12'h010, 32'h0000_0000);
    rd_chk(12'h544, 32'h0000_0001);
    wr_reg(12'h010, 32'h0000_0001);
    rd_chk(12'h548, 32'h0000_0001);
    rd_chk(12'h544, 32'h0000_0000);
    $display("motion and snapshots done");
    wr_reg(12'h004, 32'h0000_0001);
    @(posedge clk);
    rd_chk(12'h110, 32'h0000_0001);
    mv(2'h1, 2);
    rd_chk(12'h514, 32'h0000_0000);
    wr_reg(12'h51c, 32'h8000_0000);
    repeat (8) @(posedge clk);
    wr_reg(12'h500, 32'h0000_0000);
    en_tb <= 1'b0;
    repeat (20) @(posedge clk);
    $display("stop and release done");
    final_report;
  end
endmodule // qd_ctrl_tb_top
